// file: spicsu_core.sv
// SPI client shift unit: samples host clock and select, shifts bytes, keeps flags and the interrupt.
// Assumes an external host drives the clock and select pins; control bits arrive as plain ports.
`timescale 1ns/1ps
`include "spicsu_defines.svh"

module spicsu_core #(
    parameter int BITS = `SPICSU_BYTE_BITS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sck_pin,
    input wire logic ss_n_pin,
    input wire logic mosi_pin,
    output logic miso_o,
    output logic miso_oe_n,
    input wire logic enable,
    input wire logic miso_dir_out,
    input wire logic buffer_mode_on,
    input wire logic buffer_wait_receive,
    input wire logic [`SPICSU_MODE_W-1:0] mode,
    input wire logic bit_order_select,
    input wire logic normal_irq_enable,
    input wire logic receive_done_ie,
    input wire logic transfer_done_ie,
    input wire logic tx_empty_ie,
    input wire logic select_trigger_ie,
    input wire logic data_wr,
    input wire logic [BITS-1:0] data_wdata,
    input wire logic clr_transfer_flag,
    input wire logic clr_write_collision_flag,
    input wire logic clr_receive_done_flag,
    input wire logic clr_transfer_done_flag,
    input wire logic clr_select_trigger_flag,
    output logic [BITS-1:0] rx_data,
    output logic transfer_flag,
    output logic write_collision_flag,
    output logic tx_buffer_empty_flag,
    output logic receive_done_flag,
    output logic transfer_done_flag,
    output logic select_trigger_flag,
    output logic sck_event,
    output logic irq
);

    localparam int CW = (BITS > 1) ? $clog2(BITS) : 1;
    localparam logic [CW-1:0] LAST_BIT = CW'(BITS - 1);

    generate
        if (BITS < 2) begin : g_bad_bits
            $error("spicsu_core needs at least two bits per transfer");
        end
    endgenerate

    typedef struct packed {
        spicsu_pkg::spicsu_phase_t phase;
        logic sck_prev;
        logic ss_prev;
        logic [CW-1:0] cnt;
        logic [BITS-1:0] rx_sh;
        logic [BITS-1:0] sr;
        logic [BITS-1:0] txbuf;
        logic tx_empty_source;
        logic [BITS-1:0] rxd;
        logic miso;
        logic miso_oe_n;
        logic sck_evt;
        logic irq;
        logic done_p1;
        logic done_p2;
        logic loaded_p1;
        logic loaded_p2;
        logic sr_full;
    } spicsu_core_state_t;

    spicsu_core_state_t st_q;
    spicsu_core_state_t st_d;

    logic sck_s;
    logic ss_n_s;
    logic mosi_s;
    logic set_if;
    logic set_write_collision_flag;
    logic set_rxc;
    logic set_txc;
    logic set_ssi;
    logic f_if;
    logic f_write_collision_flag;
    logic f_rxc;
    logic f_txc;
    logic f_ssi;

    // Pins only ever feed the synchroniser; the unit never drives select, host-out or clock.
    spicsu_sync #(
        .W(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in({sck_pin, ss_n_pin, mosi_pin}),
        .reset_val(3'h2),
        .sync_out({sck_s, ss_n_s, mosi_s})
    );

    logic sck_rise;
    logic sck_fall;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic setup_edge;
    logic selected;
    logic ss_fall;
    logic [BITS-1:0] rx_next;
    logic byte_done;
    logic busy;

    always_comb begin
        sck_rise = sck_s & ~st_q.sck_prev;
        sck_fall = ~sck_s & st_q.sck_prev;
        // Leading edge direction comes from the upper mode bit.
        lead_edge = mode[`SPICSU_MODE_BIT_FALLING_LEAD] ? sck_fall : sck_rise;
        trail_edge = mode[`SPICSU_MODE_BIT_FALLING_LEAD] ? sck_rise : sck_fall;
        // Sampling and setup always sit on opposite edges.
        sample_edge = mode[`SPICSU_MODE_BIT_TRAIL_SAMPLE] ? trail_edge : lead_edge;
        setup_edge = mode[`SPICSU_MODE_BIT_TRAIL_SAMPLE] ? lead_edge : trail_edge;
        selected = enable & ~ss_n_s;
        ss_fall = st_q.ss_prev & ~ss_n_s;
        if (bit_order_select == `SPICSU_BIT_ORDER_LSB_FIRST) begin
            rx_next = {mosi_s, st_q.rx_sh[BITS-1:1]};
        end else begin
            rx_next = {st_q.rx_sh[BITS-2:0], mosi_s};
        end
        byte_done = (st_q.phase == spicsu_pkg::SPICSU_ACTIVE) && selected && sample_edge && (st_q.cnt == LAST_BIT);
        busy = (st_q.phase == spicsu_pkg::SPICSU_ACTIVE) && (st_q.cnt != '0);
    end

    always_comb begin
        st_d = st_q;
        set_if = 1'b0;
        set_write_collision_flag = 1'b0;
        set_rxc = 1'b0;
        set_txc = 1'b0;
        set_ssi = 1'b0;
        st_d.sck_prev = sck_s;
        st_d.ss_prev = ss_n_s;
        st_d.done_p1 = 1'b0;
        st_d.done_p2 = st_q.done_p1;
        st_d.loaded_p1 = 1'b0;
        st_d.loaded_p2 = st_q.loaded_p1;
        // The clock event mirrors the synchronised clock, so each level lasts as long as the host phase.
        st_d.sck_evt = sck_s;

        case (st_q.phase)
            spicsu_pkg::SPICSU_IDLE: begin
                st_d.cnt = '0;
                if (selected) begin
                    st_d.phase = spicsu_pkg::SPICSU_ACTIVE;
                    st_d.rx_sh = '0;
                    st_d.sr_full = 1'b0;
                end
            end
            spicsu_pkg::SPICSU_ACTIVE: begin
                if (!selected) begin
                    // Deselect drops the partial received byte; the shift register keeps its partly shifted contents.
                    st_d.phase = spicsu_pkg::SPICSU_IDLE;
                    st_d.cnt = '0;
                    st_d.rx_sh = '0;
                end else begin
                    if (setup_edge && st_q.cnt != '0) begin
                        if (bit_order_select == `SPICSU_BIT_ORDER_LSB_FIRST) begin
                            st_d.sr = {1'b0, st_q.sr[BITS-1:1]};
                        end else begin
                            st_d.sr = {st_q.sr[BITS-2:0], 1'b0};
                        end
                    end
                    if (sample_edge) begin
                        st_d.rx_sh = rx_next;
                        st_d.cnt = (st_q.cnt == LAST_BIT) ? '0 : st_q.cnt + CW'(1);
                    end
                    if (byte_done) begin
                        st_d.rxd = rx_next;
                        if (!buffer_mode_on) begin
                            set_if = 1'b1;
                        end else begin
                            st_d.done_p1 = 1'b1;
                            if (!st_q.tx_empty_source) begin
                                // Buffered byte moves into the shift register and the buffer reads empty.
                                st_d.sr = st_q.txbuf;
                                st_d.tx_empty_source = 1'b1;
                                st_d.loaded_p1 = 1'b1;
                                st_d.sr_full = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                st_d.phase = spicsu_pkg::SPICSU_IDLE;
            end
        endcase

        if (buffer_mode_on) begin
            // With buffer_wait_receive set, only the first buffered byte while deselected moves on to the shift register; later ones wait.
            if (buffer_wait_receive && ss_n_s && !st_q.tx_empty_source && !st_q.sr_full) begin
                st_d.sr = st_q.txbuf;
                st_d.tx_empty_source = 1'b1;
                st_d.sr_full = 1'b1;
            end
            if (data_wr) begin
                if (st_d.tx_empty_source) begin
                    // The shift register is left as is, so with buffer_wait_receive clear the first transfer sends its old contents.
                    st_d.txbuf = data_wdata;
                    st_d.tx_empty_source = 1'b0;
                end
                // A write against a full buffer is simply lost.
            end
            set_rxc = st_q.done_p1;
            set_txc = st_q.done_p2 && !st_q.loaded_p2 && st_q.tx_empty_source;
            set_ssi = ss_fall && enable;
        end else begin
            st_d.tx_empty_source = 1'b1;
            if (data_wr) begin
                if (busy) begin
                    set_write_collision_flag = 1'b1;
                end else begin
                    st_d.sr = data_wdata;
                end
            end
        end

        // Output enable is low only when the pin is configured as output and the unit is selected.
        st_d.miso_oe_n = ~(miso_dir_out & selected);
        st_d.miso = (bit_order_select == `SPICSU_BIT_ORDER_LSB_FIRST) ? st_d.sr[0] : st_d.sr[BITS-1];

        // Enable sets are gated by mode; the request holds until the flag clears.
        if (buffer_mode_on) begin
            st_d.irq = (f_rxc & receive_done_ie) | (f_txc & transfer_done_ie) | (st_q.tx_empty_source & tx_empty_ie)
                | (f_ssi & select_trigger_ie);
        end else begin
            st_d.irq = (f_if | f_write_collision_flag) & normal_irq_enable;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q.phase <= spicsu_pkg::SPICSU_IDLE;
            st_q.sck_prev <= 1'b0;
            st_q.ss_prev <= 1'b1;
            st_q.cnt <= '0;
            st_q.rx_sh <= '0;
            st_q.sr <= '0;
            st_q.txbuf <= '0;
            st_q.tx_empty_source <= 1'b1;
            st_q.rxd <= '0;
            st_q.miso <= 1'b0;
            st_q.miso_oe_n <= 1'b1;
            st_q.sck_evt <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.done_p1 <= 1'b0;
            st_q.done_p2 <= 1'b0;
            st_q.loaded_p1 <= 1'b0;
            st_q.loaded_p2 <= 1'b0;
            st_q.sr_full <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    spicsu_flag u_flag_if (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_p(set_if),
        .clr_p(clr_transfer_flag),
        .flag(f_if)
    );
    spicsu_flag u_flag_write_collision_flag (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_p(set_write_collision_flag),
        .clr_p(clr_write_collision_flag),
        .flag(f_write_collision_flag)
    );
    spicsu_flag u_flag_rxc (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_p(set_rxc),
        .clr_p(clr_receive_done_flag),
        .flag(f_rxc)
    );
    spicsu_flag u_flag_txc (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_p(set_txc),
        .clr_p(clr_transfer_done_flag),
        .flag(f_txc)
    );
    spicsu_flag u_flag_ssi (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .set_p(set_ssi),
        .clr_p(clr_select_trigger_flag),
        .flag(f_ssi)
    );

    assign miso_o = st_q.miso;
    assign miso_oe_n = st_q.miso_oe_n;
    assign rx_data = st_q.rxd;
    assign transfer_flag = f_if;
    assign write_collision_flag = f_write_collision_flag;
    assign tx_buffer_empty_flag = st_q.tx_empty_source;
    assign receive_done_flag = f_rxc;
    assign transfer_done_flag = f_txc;
    assign select_trigger_flag = f_ssi;
    assign sck_event = st_q.sck_evt;
    assign irq = st_q.irq;

endmodule : spicsu_core

// file: spicsu_defines.svh
// Constants for the SPI client shift unit: field encodings, widths and timing counts.
// Assumes it is included by its bare name from the package and the design modules.
`ifndef SPICSU_DEFINES_SVH
`define SPICSU_DEFINES_SVH

`define SPICSU_BYTE_BITS 8
`define SPICSU_MODE_W 2
`define SPICSU_MODE_RISE_SAMPLE 2'h0
`define SPICSU_MODE_RISE_SETUP 2'h1
`define SPICSU_MODE_FALL_SAMPLE 2'h2
`define SPICSU_MODE_FALL_SETUP 2'h3
`define SPICSU_MODE_BIT_FALLING_LEAD 1
`define SPICSU_MODE_BIT_TRAIL_SAMPLE 0
`define SPICSU_BIT_ORDER_MSB_FIRST 1'h0
`define SPICSU_BIT_ORDER_LSB_FIRST 1'h1
`define SPICSU_SCK_MIN_PHASE_CYC 2
`define SPICSU_SYNC_STAGES 2

`endif

// file: spicsu_pkg.sv
// Types shared by the SPI client shift unit modules.
// Assumes the constants header sits in the same folder.
`include "spicsu_defines.svh"

package spicsu_pkg;

    typedef enum logic {
        SPICSU_IDLE,
        SPICSU_ACTIVE
    } spicsu_phase_t;

endpackage : spicsu_pkg

// file: spicsu_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is independent; no bus coherence is promised across bits.
`timescale 1ns/1ps

module spicsu_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    input wire logic [W-1:0] reset_val,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [1:0] fill;
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spicsu_sync_state_t;

    spicsu_sync_state_t st_q;
    spicsu_sync_state_t st_d;

    generate
        if (W < 1) begin : g_bad_w
            $error("spicsu_sync width must be at least one");
        end
    endgenerate

    always_comb begin
        st_d.fill = (st_q.fill == 2'h2) ? st_q.fill : st_q.fill + 2'h1;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    // Until both stages hold a real sample the tie value is shown, so no false edge follows reset.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = (st_q.fill == 2'h2) ? st_q.s2 : reset_val;

endmodule : spicsu_sync

// file: spicsu_flag.sv
// Sticky status flag: hardware sets it, software clears it with a pulse.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps

module spicsu_flag (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic set_p,
    input wire logic clr_p,
    output logic flag
);

    typedef struct packed {
        logic f;
    } spicsu_flag_state_t;

    spicsu_flag_state_t st_q;
    spicsu_flag_state_t st_d;

    // A set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        st_d = st_q;
        if (set_p) begin
            st_d.f = 1'b1;
        end else if (clr_p) begin
            st_d.f = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.f;

endmodule : spicsu_flag

// file: spicsu_core_props.sv
// Concurrent checks on the ports of the SPI client shift unit, bound into every core instance.
// Assumes one clock domain and pins driven a little after the rising edge of clk_sys.
`timescale 1ns/1ps

module spicsu_core_props (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic sck_pin,
    input wire logic ss_n_pin,
    input wire logic data_wr,
    input wire logic buffer_mode_on,
    input wire logic normal_irq_enable,
    input wire logic receive_done_ie,
    input wire logic transfer_done_ie,
    input wire logic tx_empty_ie,
    input wire logic select_trigger_ie,
    input wire logic miso_oe_n,
    input wire logic miso_dir_out,
    input wire logic [7:0] rx_data,
    input wire logic transfer_flag,
    input wire logic write_collision_flag,
    input wire logic tx_buffer_empty_flag,
    input wire logic receive_done_flag,
    input wire logic transfer_done_flag,
    input wire logic select_trigger_flag,
    input wire logic sck_event,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Five samples high outlast the synchroniser, so the halt must have landed.
    sequence s_deselected;
        ss_n_pin [*5];
    endsequence
    sequence s_byte_end;
        $rose(tx_buffer_empty_flag) && buffer_mode_on && !ss_n_pin;
    endsequence

    a_sck_event_lag: assert property ($past(resetn, 3) |-> sck_event == $past(sck_pin, 3))
        else $error("sck event does not follow the clock pin");
    a_sck_event_len: assert property ($rose(sck_event) |=> sck_event)
        else $error("sck event shorter than two cycles");
    a_miso_tristate: assert property (s_deselected |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_miso_input: assert property (!miso_dir_out |=> miso_oe_n)
        else $error("miso driven while configured as input");
    a_halt_keeps: assert property (s_deselected |=> $stable(rx_data) && !$rose(transfer_flag))
        else $error("activity while deselected");
    a_collide_cause: assert property ($rose(write_collision_flag) |-> ($past(data_wr) || $past(data_wr, 2)) && !buffer_mode_on)
        else $error("collision flag without a normal mode write");
    a_empty_clears: assert property (buffer_mode_on && tx_buffer_empty_flag && data_wr |-> ##[1:2] !tx_buffer_empty_flag)
        else $error("empty flag not cleared by a buffer write");
    a_rxc_follows: assert property (s_byte_end |=> receive_done_flag)
        else $error("receive done not one cycle after empty flag");
    a_txc_order: assert property ($rose(transfer_done_flag) |-> $past(receive_done_flag))
        else $error("transfer done before receive done");
    a_irq_normal: assert property (!$past(buffer_mode_on) |->
        irq == $past((transfer_flag || write_collision_flag) && normal_irq_enable))
        else $error("normal mode interrupt wrong");
    a_irq_buffer: assert property ($past(buffer_mode_on) |-> irq == $past((receive_done_flag && receive_done_ie)
        || (transfer_done_flag && transfer_done_ie) || (tx_buffer_empty_flag && tx_empty_ie)
        || (select_trigger_flag && select_trigger_ie)))
        else $error("buffer mode interrupt wrong");
    a_trigger_mode: assert property ($rose(select_trigger_flag) |-> $past(buffer_mode_on))
        else $error("select trigger outside buffer mode");
endmodule : spicsu_core_props

bind spicsu_core spicsu_core_props u_props (.clk_sys, .resetn, .sck_pin, .ss_n_pin, .data_wr, .buffer_mode_on,
    .normal_irq_enable, .receive_done_ie, .transfer_done_ie, .tx_empty_ie, .select_trigger_ie, .miso_oe_n, .rx_data,
    .transfer_flag, .write_collision_flag, .tx_buffer_empty_flag, .receive_done_flag, .transfer_done_flag,
    .select_trigger_flag, .sck_event, .irq, .miso_dir_out);

// file: spicsu_host_model.sv
// Behavioural SPI host that drives clock, select and host-out, and captures the client line.
// Assumes clk_sys is the client's clock; every pin change lands 1 ns after its rising edge.
`timescale 1ns/1ps

module spicsu_host_model (
    input wire logic clk_sys,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    output logic sck_pin,
    output logic ss_n_pin,
    output logic mosi_pin
);
    logic last_q = 1'h0;
    logic miso_line;

    // A released line shows the inverse of its last value, so a stale bit never passes.
    assign miso_line = miso_oe_n ? ~last_q : miso_o;
    always @(posedge clk_sys) if (!miso_oe_n) last_q <= miso_o;
    initial begin
        sck_pin = 1'h0;
        ss_n_pin = 1'h1;
        mosi_pin = 1'h0;
    end

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : waitc

    task automatic xfer(input logic [1:0] m, input logic lsb, input logic [7:0] tx, input int n, output logic [7:0] rx);
        int k;
        rx = 8'h00;
        waitc(1);
        sck_pin = m[1];
        waitc(4);
        ss_n_pin = 1'h0;
        if (!m[0]) mosi_pin = tx[lsb ? 0 : 7];
        waitc(4);
        for (int i = 0; i < n; i++) begin
            for (int h = 0; h < 2; h++) begin
                sck_pin = ~sck_pin;
                if (h == int'(m[0])) begin
                    // Capture mid-phase: the client answers a few cycles after each setup edge.
                    waitc(2);
                    rx[lsb ? i : 7 - i] = miso_line;
                    waitc(2);
                end else begin
                    k = m[0] ? i : i + 1;
                    if (k < 8) mosi_pin = tx[lsb ? k : 7 - k];
                    waitc(4);
                end
            end
        end
        ss_n_pin = 1'h1;
        mosi_pin = ~mosi_pin;
        waitc(4);
    endtask : xfer
endmodule : spicsu_host_model

// file: spi_client_shift_unit_test.sv
// Self-checking bench for the SPI client shift unit with a behavioural host on its pins.
// Assumes the checker binds itself into the core and the host model takes 20 ns clock periods.
`timescale 1ns/1ps

module spi_client_shift_unit_test;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic enable = 1'h0, miso_dir_out = 1'h1, buffer_mode_on = 1'h0, buffer_wait_receive = 1'h0;
    logic bit_order_select = 1'h0, normal_irq_enable = 1'h1, receive_done_ie = 1'h1, transfer_done_ie = 1'h1;
    logic tx_empty_ie = 1'h1, select_trigger_ie = 1'h1, data_wr = 1'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] data_wdata = 8'h00, rx_data, r, wb, tx;
    logic clr_transfer_flag = 1'h0, clr_write_collision_flag = 1'h0, clr_receive_done_flag = 1'h0;
    logic clr_transfer_done_flag = 1'h0, clr_select_trigger_flag = 1'h0;
    logic sck_pin, ss_n_pin, mosi_pin, miso_o, miso_oe_n, transfer_flag, write_collision_flag;
    logic tx_buffer_empty_flag, receive_done_flag, transfer_done_flag, select_trigger_flag, sck_event, irq;
    int num_errors = 0, checks = 0, cycles = 0;

    spicsu_core uut (.clk_sys, .resetn, .sck_pin, .ss_n_pin, .mosi_pin, .miso_o, .miso_oe_n, .enable,
        .miso_dir_out, .buffer_mode_on, .buffer_wait_receive, .mode, .bit_order_select, .normal_irq_enable,
        .receive_done_ie, .transfer_done_ie, .tx_empty_ie, .select_trigger_ie, .data_wr, .data_wdata,
        .clr_transfer_flag, .clr_write_collision_flag, .clr_receive_done_flag, .clr_transfer_done_flag,
        .clr_select_trigger_flag, .rx_data, .transfer_flag, .write_collision_flag, .tx_buffer_empty_flag,
        .receive_done_flag, .transfer_done_flag, .select_trigger_flag, .sck_event, .irq);
    spicsu_host_model host (.clk_sys, .miso_o, .miso_oe_n, .sck_pin, .ss_n_pin, .mosi_pin);

    always #10 clk_sys = ~clk_sys;

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // The ceiling is far above the roughly 1150 cycles the tests need.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] b);
        cyc(1);
        data_wr = 1'h1;
        data_wdata = b;
        cyc(1);
        data_wr = 1'h0;
    endtask : wr

    task automatic clr_all;
        cyc(1);
        {clr_transfer_flag, clr_write_collision_flag, clr_receive_done_flag} = 3'h7;
        {clr_transfer_done_flag, clr_select_trigger_flag} = 2'h3;
        cyc(1);
        {clr_transfer_flag, clr_write_collision_flag, clr_receive_done_flag} = 3'h0;
        {clr_transfer_done_flag, clr_select_trigger_flag} = 2'h0;
        cyc(2);
    endtask : clr_all

    task automatic t_normal;
        for (int i = 0; i < 8; i++) begin
            mode = 2'(i >> 1);
            bit_order_select = i[0];
            wb = 8'h1E + 8'(i * 17);
            tx = ~wb ^ 8'(i);
            wr(wb);
            host.xfer(mode, bit_order_select, tx, 8, r);
            chk(r, wb);
            chk(rx_data, tx);
            chk(transfer_flag, 8'h01);
            chk(irq, 8'h01);
            clr_all;
            chk(irq, 8'h00);
        end
        $display("normal mode test done");
    endtask : t_normal

    task automatic t_collide;
        mode = 2'h0;
        bit_order_select = 1'h0;
        wr(8'h3C);
        fork
            host.xfer(2'h0, 1'h0, 8'h5A, 4, r);
            begin
                cyc(14);
                wr(8'hC3);
            end
        join
        cyc(2);
        chk(write_collision_flag, 8'h01);
        chk(r, 8'h30);
        chk(transfer_flag, 8'h00);
        chk(rx_data, tx);
        chk(irq, 8'h01);
        clr_all;
        $display("collision test done");
    endtask : t_collide

    task automatic t_buf1;
        buffer_mode_on = 1'h1;
        buffer_wait_receive = 1'h1;
        clr_all;
        wr(8'h43);
        cyc(3);
        chk(tx_buffer_empty_flag, 8'h01);
        wr(8'h44);
        cyc(2);
        chk(tx_buffer_empty_flag, 8'h00);
        wr(8'h45);
        host.xfer(2'h0, 1'h0, 8'h11, 8, r);
        chk(r, 8'h43);
        chk(tx_buffer_empty_flag, 8'h01);
        chk(receive_done_flag, 8'h01);
        chk(transfer_done_flag, 8'h00);
        chk(select_trigger_flag, 8'h01);
        chk(irq, 8'h01);
        clr_all;
        host.xfer(2'h0, 1'h0, 8'h22, 8, r);
        chk(r, 8'h44);
        chk(transfer_done_flag, 8'h01);
        chk(rx_data, 8'h22);
        $display("buffer wait receive test done");
    endtask : t_buf1

    task automatic t_buf0;
        buffer_wait_receive = 1'h0;
        clr_all;
        wr(8'h46);
        cyc(3);
        chk(tx_buffer_empty_flag, 8'h00);
        host.xfer(2'h0, 1'h0, 8'h33, 8, r);
        chk(r, 8'(8'h44 << 7));
        chk(tx_buffer_empty_flag, 8'h01);
        clr_all;
        host.xfer(2'h0, 1'h0, 8'h55, 8, r);
        chk(r, 8'h46);
        miso_dir_out = 1'h0;
        fork
            host.xfer(2'h0, 1'h0, 8'h77, 8, r);
            begin
                cyc(20);
                chk(miso_oe_n, 8'h01);
            end
        join
        chk(rx_data, 8'h77);
        miso_dir_out = 1'h1;
        $display("buffer dummy byte test done");
    endtask : t_buf0

    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        resetn = 1'h1;
        cyc(4);
        enable = 1'h1;
        cyc(4);
        t_normal;
        t_collide;
        t_buf1;
        t_buf0;
        close_out;
    end
endmodule : spi_client_shift_unit_test
